// *** design/can_mh_pkg.sv ***
// Function
// - Data bytes of a transmit object may be updated at any time.
// - Mask 0x0087, then object number: data bytes updated, request set.
// - fresh_data_flag is cleared when the new transmission starts.
// - Standard identifier frames store zeros in lower eighteen bits.
// - With receive_irq_enable, a stored data frame sets object_irq_pending.
// - Stored data frame writes length code and all eight data bytes.
// - An object read through the interface set is always consistent.
// - Mask 0x007F reads whole object; clears fresh and pending in RAM only.
// - lost_message_flag marks overrun and is never cleared by hardware.
// - transmit_request on a receive object sends a remote frame.
// - Data frame arriving before the remote frame clears transmit_request.
// - FIFO frames go to the lowest-numbered available member.
// - Storing sets fresh_data_flag; fresh non-last members are locked.
// - With no member released, frames overwrite the last member.
// - Read transfer returns control flags as they were before clearing.
// - Stored arbitration bits hold the identifier actually received.
// - Busy is set while an interface transfer runs and cleared after.
package can_mh_pkg;

	// ==================================================================
	// Register offsets (byte addresses, one word each)
	localparam int        ADDR_W     = 5;
	localparam logic [4:0] A_CMASK   = 5'h00;
	localparam logic [4:0] A_CREQ    = 5'h04;
	localparam logic [4:0] A_MASK    = 5'h08;
	localparam logic [4:0] A_ARB     = 5'h0C;
	localparam logic [4:0] A_MCTL    = 5'h10;
	localparam logic [4:0] A_DATA_A  = 5'h14;
	localparam logic [4:0] A_DATA_B  = 5'h18;

	// ==================================================================
	// Command mask bits and the two common command values
	localparam int CM_WR     = 7;
	localparam int CM_MASK   = 6;
	localparam int CM_ARB    = 5;
	localparam int CM_CTRL   = 4;
	localparam int CM_CLRPND = 3;
	localparam int CM_TXRQ   = 2;
	localparam int CM_DA     = 1;
	localparam int CM_DB     = 0;
	localparam logic [7:0] CMD_DATA_UPD = 8'h87;
	localparam logic [7:0] CMD_READ_ALL = 8'h7F;

	// ==================================================================
	// Field positions in the request, arbitration, mask and control words
	localparam int CRR_BUSY  = 15;
	localparam int CRR_NUM_W = 6;
	localparam int AR_VALID  = 31;
	localparam int AR_XTD    = 30;
	localparam int AR_DIR    = 29;
	localparam int MK_MASK_EXTENDED_FLAG   = 31;
	localparam int MK_MASK_DIRECTION_FLAG   = 30;
	localparam int MC_FRESH  = 15;
	localparam int MC_LOST   = 14;
	localparam int MC_IRQP   = 13;
	localparam int MC_USE_ACCEPTANCE_MASK  = 12;
	localparam int MC_TRANSMIT_IRQ_ENABLE   = 11;
	localparam int MC_RECEIVE_IRQ_ENABLE   = 10;
	localparam int MC_REMOTE_ANSWER_ENABLE  = 9;
	localparam int MC_TXRQ   = 8;
	localparam int MC_EOB    = 7;
	localparam int STD_LOW_W = 18;

	// ==================================================================
	// Stored object content and per-object flags
	typedef struct packed {
		logic [28:0] identifier_bits;
		logic        xtd;
		logic [28:0] acceptance_mask_bits;
		logic        mask_extended_flag;
		logic        mask_direction_flag;
		logic        use_acceptance_mask;
		logic [3:0]  frame_length_code;
		logic [63:0] data;
	} ram_word_t;

	typedef struct packed {
		logic object_valid;
		logic end_of_block;
		logic dir;
		logic fresh_data_flag;
		logic lost_message_flag;
		logic object_irq_pending;
		logic transmit_request;
		logic receive_irq_enable;
		logic transmit_irq_enable;
		logic remote_answer_enable;
	} obj_flags_t;

	typedef enum logic [1:0] {S_IDLE, S_IF, S_RX, S_TX} mh_state_t;

endpackage : can_mh_pkg

// *** design/msg_ram_if.sv ***
`timescale 1ns/1ps
// ======================================================================
// Port between the handler and its message store.
interface msg_ram_if #(parameter int AW = 5);
	logic [AW-1:0]         addr;
	logic                  we;
	can_mh_pkg::ram_word_t wdata;
	can_mh_pkg::ram_word_t rdata;
	modport ctrl (output addr, output we, output wdata, input rdata);
	modport mem  (input addr, input we, input wdata, output rdata);
endinterface : msg_ram_if

// *** design/msg_ram.sv ***
`timescale 1ns/1ps
// ======================================================================
// Message store: one port, read data registered, old data read on write.
module msg_ram #(
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input wire logic i_clk_sys,
	msg_ram_if.mem   m
);
	import can_mh_pkg::*;

	ram_word_t mem [DEPTH];

	// Read-before-write keeps the merge in the handler simple.
	always_ff @(posedge i_clk_sys) begin
		if (m.we) begin
			mem[m.addr] <= m.wdata;
		end
		m.rdata <= mem[m.addr];
	end

endmodule : msg_ram

// *** design/can_message_object_handler.sv ***
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// ======================================================================
// Message handler: interface register set, receive storage, transmit
// selection. One state machine owns the store, so every transfer is
// atomic against reception and transmission.
module can_message_object_handler #(
	parameter int N  = 32,
	parameter int IW = 5
) (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst,
	input  wire logic [can_mh_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic [31:0]                o_rdata,
	input  wire logic                  i_rx_frame,
	input  wire logic                  i_rx_remote,
	input  wire logic                  i_rx_xtd,
	input  wire logic [28:0]           i_rx_id,
	input  wire logic [3:0]            i_rx_dlc,
	input  wire logic [63:0]           i_rx_data,
	input  wire logic [N-1:0]          i_rx_match,
	input  wire logic                  i_tx_ready,
	input  wire logic                  i_tx_done,
	input  wire logic                  i_tx_ok,
	output logic                       o_tx_start,
	output logic                       o_tx_remote,
	output logic                       o_tx_xtd,
	output logic [28:0]                o_tx_id,
	output logic [3:0]                 o_tx_dlc,
	output logic [63:0]                o_tx_data,
	output logic [N-1:0]               o_irq_pend
);
	import can_mh_pkg::*;

	// ==================================================================
	// State
	typedef struct packed {
		mh_state_t            st;
		logic [7:0]           cmask;
		logic                 busy;
		logic [IW-1:0]        num;
		ram_word_t            bw;
		obj_flags_t           bf;
		obj_flags_t [N-1:0]   fl;
		logic                 rx_pend;
		logic                 rx_remote;
		logic                 rx_xtd;
		logic [28:0]          rx_id;
		logic [3:0]           rx_dlc;
		logic [63:0]          rx_data;
		logic [N-1:0]         rx_match;
		logic [IW-1:0]        rx_obj;
		logic                 tx_busy;
		logic [IW-1:0]        tx_obj;
		logic                 tx_start;
		logic                 tx_remote;
		logic                 tx_xtd;
		logic [28:0]          tx_id;
		logic [3:0]           tx_dlc;
		logic [63:0]          tx_data;
		logic [31:0]          rdata;
	} state_t;

	state_t        r;
	state_t        n;
	msg_ram_if #(.AW(IW)) ram_bus ();
	logic [N-1:0]  valid_v;
	logic [N-1:0]  eob_v;
	logic [N-1:0]  dir_v;
	logic [N-1:0]  fresh_v;
	logic [N-1:0]  lost_v;
	logic [N-1:0]  irqp_v;
	logic [N-1:0]  txrq_v;
	logic [N-1:0]  remote_answer_enable_v;
	logic [IW:0]   rx_sel;
	logic [IW:0]   rr_sel;
	logic [IW:0]   tx_sel;
	logic          num_ok;

	msg_ram #(.DEPTH(N), .AW(IW)) u_ram (
		.i_clk_sys (i_clk_sys),
		.m         (ram_bus.mem)
	);

	// ==================================================================
	// Helpers
	// Lowest set bit wins, matching the object priority order.
	function automatic logic [IW:0] first_set(input logic [N-1:0] v);
		logic [IW:0] res;
		res = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				res = {1'b1, IW'(i)};
			end
		end
		return res;
	endfunction : first_set

	// Copies the fields the command mask selects from s into d.
	function automatic ram_word_t mrg_w(input ram_word_t d,
			input ram_word_t s, input logic [7:0] cm);
		ram_word_t o;
		o = d;
		if (cm[CM_MASK]) begin
			o.acceptance_mask_bits = s.acceptance_mask_bits;
			o.mask_extended_flag   = s.mask_extended_flag;
			o.mask_direction_flag  = s.mask_direction_flag;
		end
		if (cm[CM_ARB]) begin
			o.identifier_bits = s.identifier_bits;
			o.xtd             = s.xtd;
		end
		if (cm[CM_CTRL]) begin
			o.use_acceptance_mask = s.use_acceptance_mask;
			o.frame_length_code   = s.frame_length_code;
		end
		if (cm[CM_DA]) begin
			o.data[31:0] = s.data[31:0];
		end
		if (cm[CM_DB]) begin
			o.data[63:32] = s.data[63:32];
		end
		return o;
	endfunction : mrg_w

	// Valid and direction travel with arbitration, the rest with control.
	function automatic obj_flags_t mrg_f(input obj_flags_t d,
			input obj_flags_t s, input logic [7:0] cm);
		obj_flags_t o;
		o = d;
		if (cm[CM_CTRL]) begin
			o = s;
			o.object_valid = d.object_valid;
			o.dir          = d.dir;
		end
		if (cm[CM_ARB]) begin
			o.object_valid = s.object_valid;
			o.dir          = s.dir;
		end
		return o;
	endfunction : mrg_f

	// Flag vectors for the priority pickers.
	for (genvar g = 0; g < N; g++) begin : g_vec
		assign valid_v[g] = r.fl[g].object_valid;
		assign eob_v[g]   = r.fl[g].end_of_block;
		assign dir_v[g]   = r.fl[g].dir;
		assign fresh_v[g] = r.fl[g].fresh_data_flag;
		assign lost_v[g]  = r.fl[g].lost_message_flag;
		assign irqp_v[g]  = r.fl[g].object_irq_pending;
		assign txrq_v[g]  = r.fl[g].transmit_request;
		assign remote_answer_enable_v[g] = r.fl[g].remote_answer_enable;
	end

	// A fresh member that is not the end of its block is locked, so the
	// next member takes the frame; the last member always accepts.
	assign rx_sel = first_set(r.rx_match & valid_v & ~dir_v
		& ~(fresh_v & ~eob_v));
	assign rr_sel = first_set(r.rx_match & valid_v & dir_v & remote_answer_enable_v);
	assign tx_sel = first_set(txrq_v & valid_v);
	assign num_ok = (i_wdata[CRR_NUM_W-1:0] != 6'h00)
		&& ({26'h0, i_wdata[CRR_NUM_W-1:0]} <= 32'(N));

	// ==================================================================
	// Next state
	always_comb begin
		ram_word_t  w;
		obj_flags_t f;
		w = '0;
		f = '0;
		n = r;
		n.tx_start = 1'b0;
		n.rdata = '0;
		ram_bus.addr = r.num;
		ram_bus.we = 1'b0;
		ram_bus.wdata = r.bw;

		// Register writes are taken regardless of object state.
		if (i_wr) begin
			case (i_addr)
			A_CMASK: n.cmask = i_wdata[7:0];
			A_CREQ: if (!r.busy && num_ok) begin
				n.busy = 1'b1;
				n.num = IW'(i_wdata[CRR_NUM_W-1:0] - 6'h01);
			end
			A_MASK: begin
				n.bw.acceptance_mask_bits = i_wdata[28:0];
				n.bw.mask_extended_flag = i_wdata[MK_MASK_EXTENDED_FLAG];
				n.bw.mask_direction_flag = i_wdata[MK_MASK_DIRECTION_FLAG];
			end
			A_ARB: begin
				n.bw.identifier_bits = i_wdata[28:0];
				n.bw.xtd = i_wdata[AR_XTD];
				n.bf.object_valid = i_wdata[AR_VALID];
				n.bf.dir = i_wdata[AR_DIR];
			end
			A_MCTL: begin
				n.bf.fresh_data_flag = i_wdata[MC_FRESH];
				n.bf.lost_message_flag = i_wdata[MC_LOST];
				n.bf.object_irq_pending = i_wdata[MC_IRQP];
				n.bw.use_acceptance_mask = i_wdata[MC_USE_ACCEPTANCE_MASK];
				n.bf.transmit_irq_enable = i_wdata[MC_TRANSMIT_IRQ_ENABLE];
				n.bf.receive_irq_enable = i_wdata[MC_RECEIVE_IRQ_ENABLE];
				n.bf.remote_answer_enable = i_wdata[MC_REMOTE_ANSWER_ENABLE];
				n.bf.transmit_request = i_wdata[MC_TXRQ];
				n.bf.end_of_block = i_wdata[MC_EOB];
				n.bw.frame_length_code = i_wdata[3:0];
			end
			A_DATA_A: n.bw.data[31:0] = i_wdata;
			A_DATA_B: n.bw.data[63:32] = i_wdata;
			default: ;
			endcase
		end

		// Read data stand for one cycle only; unmapped reads give zero.
		if (i_rd) begin
			case (i_addr)
			A_CMASK: n.rdata = {24'h0, r.cmask};
			A_CREQ: n.rdata = {16'h0, r.busy,
				15'(r.num) + 15'h0001};
			A_MASK: n.rdata = {r.bw.mask_extended_flag,
				r.bw.mask_direction_flag, 1'b0,
				r.bw.acceptance_mask_bits};
			A_ARB: n.rdata = {r.bf.object_valid, r.bw.xtd,
				r.bf.dir, r.bw.identifier_bits};
			A_MCTL: n.rdata = {16'h0, r.bf.fresh_data_flag,
				r.bf.lost_message_flag, r.bf.object_irq_pending,
				r.bw.use_acceptance_mask, r.bf.transmit_irq_enable,
				r.bf.receive_irq_enable, r.bf.remote_answer_enable,
				r.bf.transmit_request, r.bf.end_of_block, 3'b000,
				r.bw.frame_length_code};
			A_DATA_A: n.rdata = r.bw.data[31:0];
			A_DATA_B: n.rdata = r.bw.data[63:32];
			default: n.rdata = '0;
			endcase
		end

		// End of transmission: request stays if new data came meanwhile.
		if (i_tx_done && r.tx_busy) begin
			n.tx_busy = 1'b0;
			if (i_tx_ok) begin
				if (!r.fl[r.tx_obj].fresh_data_flag) begin
					n.fl[r.tx_obj].transmit_request = 1'b0;
				end
				if (r.fl[r.tx_obj].transmit_irq_enable) begin
					n.fl[r.tx_obj].object_irq_pending = 1'b1;
				end
			end
		end

		// One owner of the store; transfers never interleave.
		case (r.st)
		S_IDLE: begin
			if (r.busy) begin
				ram_bus.addr = r.num;
				n.st = S_IF;
			end else if (r.rx_pend) begin
				n.rx_pend = 1'b0;
				if (r.rx_remote) begin
					if (rr_sel[IW]) begin
						n.fl[rr_sel[IW-1:0]].transmit_request = 1'b1;
					end
				end else if (rx_sel[IW]) begin
					ram_bus.addr = rx_sel[IW-1:0];
					n.rx_obj = rx_sel[IW-1:0];
					n.st = S_RX;
				end
			end else if (i_tx_ready && !r.tx_busy && tx_sel[IW]) begin
				ram_bus.addr = tx_sel[IW-1:0];
				n.tx_obj = tx_sel[IW-1:0];
				n.st = S_TX;
			end
		end
		S_IF: begin
			ram_bus.addr = r.num;
			if (r.cmask[CM_WR]) begin
				// Read-modify-write; buffer then shows the object.
				w = mrg_w(ram_bus.rdata, r.bw, r.cmask);
				f = mrg_f(r.fl[r.num], r.bf, r.cmask);
				if (!r.cmask[CM_CTRL] && r.cmask[CM_TXRQ]) begin
					f.transmit_request = 1'b1;
				end
				ram_bus.we = 1'b1;
				ram_bus.wdata = w;
				n.fl[r.num] = f;
				n.bw = w;
				n.bf = f;
			end else begin
				// Buffer keeps pre-clear flags; RAM copy is cleared.
				n.bw = mrg_w(r.bw, ram_bus.rdata, r.cmask);
				n.bf = mrg_f(r.bf, r.fl[r.num], r.cmask);
				if (r.cmask[CM_CLRPND]) begin
					n.fl[r.num].object_irq_pending = 1'b0;
				end
				if (r.cmask[CM_TXRQ]) begin
					n.fl[r.num].fresh_data_flag = 1'b0;
				end
			end
			n.busy = 1'b0;
			n.st = S_IDLE;
		end
		S_RX: begin
			// Received arbitration replaces the stored one.
			w = ram_bus.rdata;
			w.identifier_bits = r.rx_xtd ? r.rx_id
				: {r.rx_id[28:STD_LOW_W], 18'h00000};
			w.xtd = r.rx_xtd;
			w.frame_length_code = r.rx_dlc;
			w.data = r.rx_data;
			ram_bus.addr = r.rx_obj;
			ram_bus.we = 1'b1;
			ram_bus.wdata = w;
			// Lost is set by hardware only here; only an interface write clears it.
			if (r.fl[r.rx_obj].fresh_data_flag) begin
				n.fl[r.rx_obj].lost_message_flag = 1'b1;
			end
			n.fl[r.rx_obj].fresh_data_flag = 1'b1;
			n.fl[r.rx_obj].transmit_request = 1'b0;
			if (r.fl[r.rx_obj].receive_irq_enable) begin
				n.fl[r.rx_obj].object_irq_pending = 1'b1;
			end
			n.st = S_IDLE;
		end
		S_TX: begin
			// Receive objects send a remote frame with their id.
			n.tx_start = 1'b1;
			n.tx_busy = 1'b1;
			n.tx_remote = !r.fl[r.tx_obj].dir;
			n.tx_xtd = ram_bus.rdata.xtd;
			n.tx_id = ram_bus.rdata.identifier_bits;
			n.tx_dlc = ram_bus.rdata.frame_length_code;
			n.tx_data = ram_bus.rdata.data;
			n.fl[r.tx_obj].fresh_data_flag = 1'b0;
			n.st = S_IDLE;
		end
		default: n.st = S_IDLE;
		endcase

		// A new frame is captured last so it is never dropped.
		if (i_rx_frame) begin
			n.rx_pend = 1'b1;
			n.rx_remote = i_rx_remote;
			n.rx_xtd = i_rx_xtd;
			n.rx_id = i_rx_id;
			n.rx_dlc = i_rx_dlc;
			n.rx_data = i_rx_data;
			n.rx_match = i_rx_match;
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_rdata     = r.rdata;
	assign o_tx_start  = r.tx_start;
	assign o_tx_remote = r.tx_remote;
	assign o_tx_xtd    = r.tx_xtd;
	assign o_tx_id     = r.tx_id;
	assign o_tx_dlc    = r.tx_dlc;
	assign o_tx_data   = r.tx_data;
	assign o_irq_pend  = irqp_v;

	// ==================================================================
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_busy_set: assert property (
		i_wr && i_addr == A_CREQ && !r.busy && num_ok |=> r.busy)
		else $error("busy not set by command request");
	a_busy_clear: assert property (
		$rose(r.busy) |-> ##[2:3] !r.busy)
		else $error("busy not cleared after transfer");
	a_upd_txrq: assert property (
		r.st == S_IF && r.cmask == CMD_DATA_UPD |=> txrq_v[r.num])
		else $error("data update did not set transmit request");
	a_std_zero: assert property (
		r.st == S_RX && !r.rx_xtd
		|-> ram_bus.we && ram_bus.wdata.identifier_bits[17:0] == 18'h0)
		else $error("standard id low bits not zero");
	a_rx_fresh: assert property (
		r.st == S_RX |=> fresh_v[$past(r.rx_obj)])
		else $error("stored frame did not set fresh data");
	a_fifo_lock: assert property (
		r.st == S_RX |-> !(fresh_v[r.rx_obj] && !eob_v[r.rx_obj]))
		else $error("locked member was written");
	a_rx_txrq: assert property (
		r.st == S_RX |=> !txrq_v[$past(r.rx_obj)])
		else $error("received frame left transmit request set");
	a_rx_irq: assert property (
		r.st == S_RX && r.fl[r.rx_obj].receive_irq_enable
		|=> irqp_v[$past(r.rx_obj)])
		else $error("receive interrupt not pending");
	a_tx_fresh: assert property (
		o_tx_start |-> !fresh_v[r.tx_obj] && r.tx_busy)
		else $error("fresh data not cleared at start");
	a_lost_kept: assert property (
		|($past(lost_v) & ~lost_v) |-> $past(r.st) == S_IF
		&& $past(r.cmask[CM_WR]))
		else $error("lost flag cleared by hardware");
	a_read_pre: assert property (
		r.st == S_IF && r.cmask == CMD_READ_ALL
		|=> r.bf.fresh_data_flag == $past(fresh_v[r.num])
		&& !fresh_v[$past(r.num)])
		else $error("read did not return pre-clear flags");

endmodule : can_message_object_handler

// *** dv/can_bus_partner.sv ***
`timescale 1ns/1ps
// ==================================================================
// Bus-side model: takes each frame from the handler and finishes it
// after a random delay, so both prompt and slow answers occur.
module can_bus_partner (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_tx_start,
	output logic      o_tx_ready = 1'b0,
	output logic      o_tx_done  = 1'b0,
	output logic      o_tx_ok    = 1'b0
);
	int seed = 17;
	int left;
	// Ready drops while a frame is on the wire; done is one cycle long.
	always @(posedge i_clk_sys) begin
		o_tx_done <= 1'b0;
		o_tx_ok <= 1'b0;
		if (i_rst) begin
			o_tx_ready <= 1'b1;
			left <= -1;
		end else if (i_tx_start) begin
			o_tx_ready <= 1'b0;
			left <= ($random(seed) & 15) + 1;
		end else if (left == 0) begin
			o_tx_done <= 1'b1;
			o_tx_ok <= 1'b1;
			o_tx_ready <= 1'b1;
			left <= -1;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
endmodule : can_bus_partner

// *** dv/can_message_object_handler_tb_top.sv ***
`timescale 1ns/1ps
// ==================================================================
// Self-checking bench: register bus tasks, frame injection, checks.
module can_message_object_handler_tb_top;
	import can_mh_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, v, arb_v, mc_v, da, db;
	logic        wr = 1'b0, rd = 1'b0, rx_frame = 1'b0;
	logic        rx_xtd = 1'b0, xtd_nx = 1'b0;
	logic [28:0] rx_id = 29'h0, tx_id, id;
	logic [3:0]  rx_dlc = 4'h0, tx_dlc;
	logic [63:0] rx_data = 64'h0, tx_data, d1, d2;
	logic [31:0] rx_match = 32'h0, irq_pend;
	logic        tx_ready, tx_done, tx_ok, tx_start, tx_remote, tx_xtd;
	int          seed = 17, fails = 0, comparisons = 0, cycles = 0;

	can_message_object_handler uut (.i_clk_sys(clk), .i_rst(rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_rx_frame(rx_frame), .i_rx_remote(1'b0),
		.i_rx_xtd(rx_xtd), .i_rx_id(rx_id), .i_rx_dlc(rx_dlc),
		.i_rx_data(rx_data), .i_rx_match(rx_match),
		.i_tx_ready(tx_ready), .i_tx_done(tx_done), .i_tx_ok(tx_ok),
		.o_tx_start(tx_start), .o_tx_remote(tx_remote),
		.o_tx_xtd(tx_xtd), .o_tx_id(tx_id), .o_tx_dlc(tx_dlc),
		.o_tx_data(tx_data), .o_irq_pend(irq_pend));
	can_bus_partner far (.i_clk_sys(clk), .i_rst(rst),
		.i_tx_start(tx_start), .o_tx_ready(tx_ready),
		.o_tx_done(tx_done), .o_tx_ok(tx_ok));

	// ==================================================================
	// Clock and hang guard.
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end

	// ==================================================================
	// Checking, verdict and expectation helpers.
	task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		$display("counts: %0d compared, %0d failed", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// Stored standard identifiers keep only the upper eleven bits.
	function automatic logic [31:0] std_arb(logic [28:0] i);
		return {3'b100, i[28:18], 18'h0};
	endfunction : std_arb
	// Control word of receive object 1 after a data frame.
	function automatic logic [31:0] rx_mc(logic lost, logic [3:0] dlc);
		return 32'hA480 | (32'(lost) << MC_LOST) | dlc;
	endfunction : rx_mc

	// ==================================================================
	// Register bus and frame tasks; strobes last exactly one cycle.
	task automatic wr_reg(logic [4:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	// Busy is polled a bounded number of times before the buffer is used.
	task automatic cmd(logic [7:0] cm, logic [31:0] num);
		wr_reg(A_CMASK, {24'h0, cm});
		wr_reg(A_CREQ, num);
		rd_reg(A_CREQ, v);
		chk("busy set", v[CRR_BUSY], 1'b1);
		for (int i = 0; i < 20 && v[CRR_BUSY] !== 1'b0; i++)
			rd_reg(A_CREQ, v);
		chk("busy clear", v[CRR_BUSY], 1'b0);
	endtask : cmd
	task automatic cfg(int n, logic [31:0] a, logic [31:0] m);
		wr_reg(A_MASK, 32'h4000_0000);
		wr_reg(A_ARB, a);
		wr_reg(A_MCTL, m);
		cmd(8'hF3, n);
	endtask : cfg
	task automatic rdobj(int n);
		cmd(CMD_READ_ALL, n);
		rd_reg(A_ARB, arb_v);
		rd_reg(A_MCTL, mc_v);
		rd_reg(A_DATA_A, da);
		rd_reg(A_DATA_B, db);
	endtask : rdobj
	task automatic rxf(logic [31:0] m, output logic [63:0] d);
		d = {$random(seed), $random(seed)};
		@(posedge clk);
		rx_frame <= 1'b1;
		rx_xtd <= xtd_nx;
		rx_id <= 29'($random(seed));
		rx_dlc <= 4'h8;
		rx_data <= d;
		rx_match <= m;
		@(posedge clk);
		rx_frame <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : rxf
	task automatic wait_tx();
		int i;
		for (i = 0; i < 80 && tx_start !== 1'b1; i++)
			@(posedge clk) #1;
		chk("tx start", tx_start, 1'b1);
	endtask : wait_tx

	// ==================================================================
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk) #1;
		chk("irq after reset", irq_pend, 32'h0);
		// A receive object with a transmit request asks by remote frame.
		id = 29'($random(seed));
		cfg(1, 32'h8000_0000 | id, 32'h0580);
		wait_tx();
		chk("remote flag", tx_remote, 1'b1);
		chk("remote id", tx_id, id);
		chk("remote xtd", tx_xtd, 1'b0);
		$display("test remote done");
		// Data frames: stored fields, pending flag, read clears, overrun.
		rxf(32'h1, d1);
		chk("irq pend", irq_pend, 32'h1);
		rdobj(1);
		chk("std id", arb_v, std_arb(rx_id));
		chk("ctl before clear", mc_v, rx_mc(0, 4'h8));
		chk("data", {db, da}, d1);
		chk("irq cleared", irq_pend, 32'h0);
		rdobj(1);
		chk("ram cleared", mc_v[15:13], 3'b000);
		rxf(32'h1, d1);
		rxf(32'h1, d2);
		rdobj(1);
		chk("lost set", mc_v, rx_mc(1, 4'h8));
		chk("newest data", {db, da}, d2);
		rdobj(1);
		chk("lost kept", mc_v[MC_LOST], 1'b1);
		// An extended frame keeps every identifier bit it arrived with.
		xtd_nx = 1'b1;
		rxf(32'h1, d1);
		xtd_nx = 1'b0;
		rdobj(1);
		chk("ext id", arb_v, {3'b110, rx_id});
		chk("ext data", {db, da}, d1);
		$display("test receive done");
		// Two-member chain: lowest member first, then last overwritten.
		cfg(2, 32'h8000_0000, 32'h0400);
		cfg(3, 32'h8000_0000, 32'h0080);
		rxf(32'h6, d1);
		rxf(32'h6, d2);
		rxf(32'h6, d2);
		rdobj(2);
		chk("fifo first", {db, da}, d1);
		chk("fifo fresh", mc_v[MC_FRESH], 1'b1);
		rdobj(3);
		chk("fifo last", {db, da}, d2);
		$display("test fifo done");
		// Data-only update of a live transmit object starts sending.
		cfg(4, 32'hA000_0000 | id, 32'h0088);
		d1 = {$random(seed), $random(seed)};
		wr_reg(A_DATA_A, d1[31:0]);
		wr_reg(A_DATA_B, d1[63:32]);
		cmd(CMD_DATA_UPD, 4);
		wait_tx();
		chk("tx data", tx_data, d1);
		chk("tx kind", tx_remote, 1'b0);
		chk("tx dlc", tx_dlc, 4'h8);
		// Second update while the first frame may still be on the wire:
		// fresh data goes with the request so the request survives.
		d2 = {$random(seed), $random(seed)};
		wr_reg(A_MCTL, 32'h8188);
		wr_reg(A_DATA_A, d2[31:0]);
		wr_reg(A_DATA_B, d2[63:32]);
		cmd(8'h93, 4);
		wait_tx();
		chk("tx fresh data", tx_data, d2);
		repeat (30) @(posedge clk);
		rdobj(4);
		chk("fresh at start", mc_v[MC_FRESH], 1'b0);
		$display("test transmit done");
		print_verdict();
	end
endmodule : can_message_object_handler_tb_top
